/* File: verilog/adtrc_consts.vh */
// Purpose: Constants for the converter trigger, range and result control block
// Assumes: Byte-wide register access at documented addresses
// Notes: Addresses are 20-bit byte addresses
`ifndef ADTRC_CONSTS_VH
`define ADTRC_CONSTS_VH
`define ADTRC_A_CTRL 20'hfff30
`define ADTRC_A_TRIG 20'hfff32
`define ADTRC_A_REFCMP 20'hf0010
`define ADTRC_A_UPPER 20'hf0011
`define ADTRC_A_LOWER 20'hf0012
`define ADTRC_A_RES_LO 20'hfff1e
`define ADTRC_A_RES_HI 20'hfff1f
`define ADTRC_A_CHAN 20'hfff31
`define ADTRC_RST_00 8'h00
`define ADTRC_RST_UPPER 8'hff
`define ADTRC_RST_WORD 16'h0000
`define ADTRC_CTRL_RUN 7
`define ADTRC_CTRL_CMPEN 0
`define ADTRC_TRIG_KIND_HI 7
`define ADTRC_TRIG_KIND_LO 6
`define ADTRC_TRIG_REPEAT 5
`define ADTRC_REF_RCK 3
`define ADTRC_REF_AWC 2
`define ADTRC_REF_TYP 0
`define ADTRC_REF_WMASK 8'hcd
`define ADTRC_TRIG_WMASK 8'he3
`define ADTRC_CHAN_WMASK 8'h8f
`define ADTRC_CTRL_WMASK 8'hff
`define ADTRC_SRC_TIMER 2'h0
`define ADTRC_SRC_LINK 2'h1
`define ADTRC_SRC_RTC 2'h2
`define ADTRC_SRC_ITV 2'h3
`define ADTRC_REF_SUPPLY 2'h0
`define ADTRC_REF_INT 2'h2
`define ADTRC_BLANK_CYC 3'h4
`define ADTRC_ZERO3 3'h0
`define ADTRC_ONE3 3'h1
`endif

/* File: verilog/adtrc_core.v */
// Purpose: Trigger selection, range gating and result store for a 10-bit SAR converter
// Assumes: Analog front end returns a 10-bit result with a one-cycle done pulse
// Notes: Timing of sampling and approximation belongs to the analog side
//
// Summary of operation
// - Trigger source field picks timer ch1, event linker, RTC or interval timer.
// - Ignore further RTC or interval triggers for three clocks, except stop-wake mode.
// - Reference field: 00 supply, 10 internal 1.45 V; 01 and 11 prohibited.
// - Range bit 0 fires inside limits; 1 fires below lower or above upper.
// - Suppressed completion also leaves both result registers unchanged.
// - Stop-wake bit lets a trigger in stop convert without the processor.
// - Resolution bit: 0 is 10-bit, 1 is 8-bit.
// - Result word loads at conversion end; upper eight and two bits, low six zero.
// - Reset clears result word and result byte to zero.
// - In 8-bit resolution, result word bits 7 and 6 read zero.
// - Result byte shows upper eight bits of the conversion result.
// - Channel codes select inputs 8 to 14, or sensor and reference internally.
// - Trigger mode: 00/01 software, 10 hardware no-wait, 11 hardware wait.
// - In 10-bit mode compare upper eight result bits against limits.
// - Sequential software mode runs until run bit cleared; one-shot software self-clears.
`include "adtrc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module adtrc_core (
  input wire clk_sys,
  input wire rst_b,
  input wire [19:0] bus_addr,
  input wire bus_wr,
  input wire bus_rd,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata,
  input wire timer_ch1_interrupt,
  input wire event_linker,
  input wire rtc_interrupt,
  input wire interval_timer_interrupt,
  input wire stop_mode,
  input wire conv_done,
  input wire [9:0] conv_value,
  output wire conv_start,
  output wire stop_wake_mode,
  output wire comparator_enable,
  output wire [1:0] pos_ref_select,
  output wire resolution_select,
  output wire [3:0] channel_code,
  output wire internal_source_select,
  output wire [1:0] hw_trigger_source,
  output reg conversion_done_irq
);

  reg [7:0] ctrl_r;
  reg [7:0] trig_r;
  reg [7:0] refcmp_r;
  reg [7:0] upper_limit_r;
  reg [7:0] lower_limit_r;
  reg [7:0] chan_r;
  reg [15:0] result_word_r;
  reg [7:0] result_byte_r;
  reg [2:0] blank_cnt_r;
  reg [2:0] blank_cnt_nxt;
  reg busy_r;
  reg start_pend_r;
  reg wake_r;
  reg hw_sel;
  reg hw_take;
  reg in_window;
  reg store_ok;
  wire run;
  wire sw_mode;
  wire wait_mode;
  wire one_shot;
  wire stop_wake_convert;
  wire [7:0] cmp_value;
  wire slow_src;
  wire [9:0] stored_value;
  wire wr_ctrl;
  wire wr_trig;
  wire wr_refcmp;
  wire wr_upper;
  wire wr_lower;
  wire wr_chan;

  // Write strobe for one documented byte address
  function wr_hit;
    input [19:0] a;
    input [19:0] target;
    input w;
    begin
      wr_hit = w && (a == target);
    end
  endfunction

  // One decoded strobe per writable register keeps the update process readable
  assign wr_ctrl = wr_hit(bus_addr, `ADTRC_A_CTRL, bus_wr);
  assign wr_trig = wr_hit(bus_addr, `ADTRC_A_TRIG, bus_wr);
  assign wr_refcmp = wr_hit(bus_addr, `ADTRC_A_REFCMP, bus_wr);
  assign wr_upper = wr_hit(bus_addr, `ADTRC_A_UPPER, bus_wr);
  assign wr_lower = wr_hit(bus_addr, `ADTRC_A_LOWER, bus_wr);
  assign wr_chan = wr_hit(bus_addr, `ADTRC_A_CHAN, bus_wr);

  assign run = ctrl_r[`ADTRC_CTRL_RUN];
  assign comparator_enable = ctrl_r[`ADTRC_CTRL_CMPEN];
  assign sw_mode = ~trig_r[`ADTRC_TRIG_KIND_HI];
  assign wait_mode = trig_r[`ADTRC_TRIG_KIND_HI] & trig_r[`ADTRC_TRIG_KIND_LO];
  assign one_shot = trig_r[`ADTRC_TRIG_REPEAT];
  assign hw_trigger_source = trig_r[1:0];
  assign stop_wake_convert = refcmp_r[`ADTRC_REF_AWC];
  assign resolution_select = refcmp_r[`ADTRC_REF_TYP];
  assign pos_ref_select = refcmp_r[7:6];
  assign channel_code = chan_r[3:0];
  assign internal_source_select = chan_r[7];
  assign stop_wake_mode = wake_r;
  assign slow_src = hw_trigger_source[1];

  // Select the hardware trigger and apply the RTC/interval blanking window
  always @*
  begin
    case (hw_trigger_source)
      `ADTRC_SRC_TIMER: hw_sel = timer_ch1_interrupt;
      `ADTRC_SRC_LINK: hw_sel = event_linker;
      `ADTRC_SRC_RTC: hw_sel = rtc_interrupt;
      `ADTRC_SRC_ITV: hw_sel = interval_timer_interrupt;
      default: hw_sel = 1'b0;
    endcase
    hw_take = hw_sel && !sw_mode && comparator_enable &&
      !(slow_src && !stop_wake_convert && blank_cnt_r != `ADTRC_ZERO3);
    blank_cnt_nxt = blank_cnt_r;
    if (hw_take && slow_src && !stop_wake_convert)
      blank_cnt_nxt = `ADTRC_BLANK_CYC - `ADTRC_ONE3;
    else if (blank_cnt_r != `ADTRC_ZERO3)
      blank_cnt_nxt = blank_cnt_r - `ADTRC_ONE3;
  end

  // In 8-bit mode the two low bits are not resolved and read as zero
  assign stored_value = resolution_select ? {conv_value[9:2], 2'b00} : conv_value;
  assign cmp_value = conv_value[9:2];

  always @*
  begin
    in_window = (lower_limit_r <= cmp_value) && (cmp_value <= upper_limit_r);
    store_ok = refcmp_r[`ADTRC_REF_RCK] ? !in_window : in_window;
  end

  // Software start is the rising of run; hardware start needs run in no-wait mode
  assign conv_start = start_pend_r && !busy_r;

  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_r <= `ADTRC_RST_00;
      trig_r <= `ADTRC_RST_00;
      refcmp_r <= `ADTRC_RST_00;
      upper_limit_r <= `ADTRC_RST_UPPER;
      lower_limit_r <= `ADTRC_RST_00;
      chan_r <= `ADTRC_RST_00;
      result_word_r <= `ADTRC_RST_WORD;
      result_byte_r <= `ADTRC_RST_00;
      blank_cnt_r <= `ADTRC_ZERO3;
      busy_r <= 1'b0;
      start_pend_r <= 1'b0;
      wake_r <= 1'b0;
      conversion_done_irq <= 1'b0;
    end
    else
    begin
      blank_cnt_r <= blank_cnt_nxt;
      conversion_done_irq <= 1'b0;
      if (wr_trig)
        trig_r <= bus_wdata & `ADTRC_TRIG_WMASK;
      // Bits 5, 4 and 1 kept zero so a stray write cannot set them
      if (wr_refcmp)
        refcmp_r <= bus_wdata & `ADTRC_REF_WMASK;
      if (wr_upper)
        upper_limit_r <= bus_wdata;
      if (wr_lower)
        lower_limit_r <= bus_wdata;
      if (conv_start)
      begin
        busy_r <= 1'b1;
        start_pend_r <= 1'b0;
      end
      else if (hw_take && (wait_mode || run))
        start_pend_r <= 1'b1;
      // Stop-wake: a trigger in stop raises the wake request until the result is in
      if (hw_take && stop_mode && stop_wake_convert)
        wake_r <= 1'b1;
      if (conv_done && busy_r)
      begin
        busy_r <= 1'b0;
        wake_r <= 1'b0;
        if (store_ok)
        begin
          result_word_r <= {stored_value, 6'b000000};
          result_byte_r <= conv_value[9:2];
          conversion_done_irq <= 1'b1;
        end
        // A suppressed result leaves both result registers untouched
        if (!store_ok)
          result_word_r <= result_word_r;
        if (one_shot && sw_mode)
          ctrl_r[`ADTRC_CTRL_RUN] <= 1'b0;
        else if (!one_shot && run && sw_mode)
          start_pend_r <= 1'b1;
      end
      // Channel write aborts the conversion in flight and restarts on the new input
      if (wr_chan)
      begin
        chan_r <= bus_wdata & `ADTRC_CHAN_WMASK;
        if (busy_r)
        begin
          busy_r <= 1'b0;
          start_pend_r <= 1'b1;
        end
      end
      if (wr_ctrl)
      begin
        ctrl_r <= bus_wdata & `ADTRC_CTRL_WMASK;
        if (bus_wdata[`ADTRC_CTRL_RUN] && !run && sw_mode)
          start_pend_r <= 1'b1;
        if (!bus_wdata[`ADTRC_CTRL_RUN])
        begin
          busy_r <= 1'b0;
          start_pend_r <= 1'b0;
        end
      end
    end
  end

  // Read data registered one cycle after the read strobe
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      bus_rdata <= `ADTRC_RST_00;
    else if (bus_rd)
    begin
      case (bus_addr)
        `ADTRC_A_CTRL: bus_rdata <= ctrl_r;
        `ADTRC_A_TRIG: bus_rdata <= trig_r;
        `ADTRC_A_REFCMP: bus_rdata <= refcmp_r;
        `ADTRC_A_UPPER: bus_rdata <= upper_limit_r;
        `ADTRC_A_LOWER: bus_rdata <= lower_limit_r;
        `ADTRC_A_CHAN: bus_rdata <= chan_r;
        `ADTRC_A_RES_LO: bus_rdata <= result_word_r[7:0];
        `ADTRC_A_RES_HI: bus_rdata <= result_byte_r;
        default: bus_rdata <= `ADTRC_RST_00;
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: tb/adtrc_core_properties.sv */
// Purpose: Port-level checks on the converter trigger, range and result block
// Assumes: One clock domain, active-low asynchronous reset
// Notes: Bound onto every instance of the core
`timescale 1ns/1ps
`default_nettype none
module adtrc_core_properties (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [19:0] bus_addr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic stop_mode,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic stop_wake_mode,
  input wire logic [3:0] channel_code,
  input wire logic conversion_done_irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  sequence s_rd_lo;
    bus_rd && bus_addr == 20'hfff1e;
  endsequence
  sequence s_irq_pulse;
    conversion_done_irq ##1 !conversion_done_irq;
  endsequence
  a_irq_single: assert property (conversion_done_irq |-> s_irq_pulse)
    else $error("completion pulse longer than one cycle");
  a_irq_cause: assert property (conversion_done_irq |-> $past(conv_done))
    else $error("completion pulse without a finished conversion");
  a_wake_clear: assert property (conv_done |=> !stop_wake_mode)
    else $error("wake request survives conversion end");
  a_wake_in_stop: assert property ($rose(stop_wake_mode) |-> $past(stop_mode))
    else $error("wake request outside stop");
  a_rdata_hold: assert property (!$past(bus_rd) |-> $stable(bus_rdata))
    else $error("read data moved without a read");
  a_lo_pad_zero: assert property (s_rd_lo |=> bus_rdata[5:0] == 6'h00)
    else $error("low result byte padding not zero");
  a_start_single: assert property (conv_start |=> !conv_start)
    else $error("start held two cycles");
  a_reset_quiet: assert property ($rose(rst_b) |-> !conversion_done_irq && channel_code == 4'h0)
    else $error("outputs not cleared by reset");
endmodule
bind adtrc_core adtrc_core_properties u_adtrc_core_properties (.clk_sys(clk_sys),
  .rst_b(rst_b), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .stop_mode(stop_mode), .conv_start(conv_start), .conv_done(conv_done),
  .stop_wake_mode(stop_wake_mode), .channel_code(channel_code),
  .conversion_done_irq(conversion_done_irq));
`default_nettype wire

/* File: tb/adtrc_afe.sv */
// Purpose: Behavioural analog front end answering conversion starts
// Assumes: Latency set by the bench, random 0 to 15 per conversion, then 6
// Notes: A new start restarts the count, like an aborted conversion
`timescale 1ns/1ps
`default_nettype none
module adtrc_afe (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic conv_start,
  input wire logic [3:0] lat,
  input wire logic [9:0] sample,
  output logic conv_done,
  output logic [9:0] conv_value
);
  logic [4:0] cnt_r;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      cnt_r <= 5'h00;
    else if (conv_start)
      cnt_r <= {1'b0, lat} + 5'h01;
    else if (cnt_r != 5'h00)
      cnt_r <= cnt_r - 5'h01;
  assign conv_done = (cnt_r == 5'h01);
  // Inverted outside done so a stale sample can never pass as a result
  assign conv_value = conv_done ? sample : ~sample;
endmodule
`default_nettype wire

/* File: tb/test_adtrc_core.sv */
// Purpose: Self-checking bench for the converter trigger, range and result block
// Assumes: 25 MHz clock, fixed seed
// Notes: Expected results come from fire() and the write masks
`include "adtrc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module test_adtrc_core;
  logic clk_sys, rst_b, bus_wr, bus_rd, stop_mode, conv_start, conv_done, f, rck, typ;
  logic [19:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, v, lo, hi, wlo, whi;
  logic [3:0] trg, lat, channel_code;
  logic [9:0] sample, conv_value, s;
  logic [1:0] pos_ref_select, hw_trigger_source;
  logic stop_wake_mode, comparator_enable, resolution_select, internal_source_select, irq;
  int err_count, check_count, n_irq, n_st, n0;
  adtrc_core u_adtrc_core (.clk_sys(clk_sys), .rst_b(rst_b), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .timer_ch1_interrupt(trg[0]), .event_linker(trg[1]), .rtc_interrupt(trg[2]),
    .interval_timer_interrupt(trg[3]), .stop_mode(stop_mode), .conv_done(conv_done),
    .conv_value(conv_value), .conv_start(conv_start), .stop_wake_mode(stop_wake_mode),
    .comparator_enable(comparator_enable), .pos_ref_select(pos_ref_select),
    .resolution_select(resolution_select), .channel_code(channel_code),
    .internal_source_select(internal_source_select),
    .hw_trigger_source(hw_trigger_source), .conversion_done_irq(irq));
  adtrc_afe u_adtrc_afe (.clk_sys(clk_sys), .rst_b(rst_b), .conv_start(conv_start),
    .lat(lat), .sample(sample), .conv_done(conv_done), .conv_value(conv_value));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    n_irq += irq;
    n_st += conv_start;
  end
  function automatic logic fire(input logic [7:0] r, l, h, input logic c);
    fire = c ^ (r >= l && r <= h);
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
    // One more edge so the written value is settled before anyone looks
    @(posedge clk_sys);
  endtask
  task automatic rc(input logic [19:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    @(posedge clk_sys);
    chk(e, bus_rdata);
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_sys);
    trg <= m;
    @(posedge clk_sys);
    trg <= 4'h0;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  initial
  begin
    #4ms;
    err_count++;
    finish_test();
  end
  initial
  begin
    {rst_b, bus_wr, bus_rd, stop_mode, trg, bus_addr, bus_wdata, sample, lat} = '0;
    {n_irq, n_st, err_count, check_count, wlo, whi} = '0;
    v = $urandom(32'h51a863a4);
    wait_n(3);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++)
      rc(20'hfff1e + i[19:0], 8'h00);
    rc(`ADTRC_A_UPPER, 8'hff);
    wr(20'hfff33, 8'h5a);
    rc(20'hfff33, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      v = $urandom & 8'h9f;
      wr(`ADTRC_A_REFCMP, v);
      rc(`ADTRC_A_REFCMP, v & `ADTRC_REF_WMASK);
      chk({v[7:6], 5'h0, v[0]}, {pos_ref_select, 5'h0, resolution_select});
      wr(`ADTRC_A_TRIG, v);
      chk({v[1:0], 6'h0}, {hw_trigger_source, 6'h0});
      v = v ^ 8'h80;
      wr(`ADTRC_A_CHAN, v);
      chk(v & `ADTRC_CHAN_WMASK, {internal_source_select, 3'h0, channel_code});
    end
    wr(`ADTRC_A_CHAN, 8'h08);
    wr(`ADTRC_A_TRIG, 8'h20);
    for (int i = 0; i < 12; i++)
    begin
      s = $urandom;
      {lo, hi, rck, typ, lat} = $urandom;
      if (i < 2)
        lo = s[9:2];
      if (i == 1)
        hi = s[9:2];
      sample <= s;
      wr(`ADTRC_A_CTRL, 8'h00);
      wr(`ADTRC_A_UPPER, hi);
      wr(`ADTRC_A_LOWER, lo);
      wr(`ADTRC_A_REFCMP, {4'h0, rck, 2'h0, typ});
      n0 = n_irq;
      wr(`ADTRC_A_CTRL, 8'h81);
      wait_n(30);
      f = fire(s[9:2], lo, hi, rck);
      whi = f ? s[9:2] : whi;
      wlo = !f ? wlo : typ ? 8'h00 : {s[1:0], 6'h00};
      chk({7'h0, f}, 8'(n_irq - n0));
      rc(`ADTRC_A_RES_HI, whi);
      rc(`ADTRC_A_RES_LO, wlo);
      rc(`ADTRC_A_CTRL, 8'h01);
    end
    lat <= 4'h6;
    wr(`ADTRC_A_UPPER, 8'hff);
    wr(`ADTRC_A_LOWER, 8'h00);
    wr(`ADTRC_A_REFCMP, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      wr(`ADTRC_A_CTRL, 8'h00);
      wr(`ADTRC_A_TRIG, {6'h38, k[1:0]});
      wr(`ADTRC_A_CTRL, 8'h01);
      n0 = n_st;
      pulse(4'hf ^ (4'h1 << k));
      pulse(4'h1 << k);
      pulse(4'h1 << k);
      wait_n(40);
      chk(k < 2 ? 8'h02 : 8'h01, 8'(n_st - n0));
    end
    wr(`ADTRC_A_CTRL, 8'h00);
    wr(`ADTRC_A_REFCMP, 8'h04);
    wr(`ADTRC_A_CTRL, 8'h01);
    wait_n(25);
    stop_mode <= 1'b1;
    n0 = n_irq;
    pulse(4'h8);
    wait_n(30);
    chk(8'h01, 8'(n_irq - n0));
    stop_mode <= 1'b0;
    wr(`ADTRC_A_CTRL, 8'h00);
    wr(`ADTRC_A_REFCMP, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
